//--- hdl/fspi_pkg.sv
/*
 constants, state encoding and prescaler decode shared by both ends
 of the framed serial link.
 assumes a single 250 MHz sys_clk and a synchronous active-high reset.
*/
package fspi_pkg;
   // control word bit positions
   localparam int CTL_W = 16;
   localparam int CTL_FRAME_EN = 14;
   localparam int CTL_FRAME_DIR = 13;
   localparam int CTL_WIDTH = 10;
   localparam int CTL_EDGE = 8;
   localparam int CTL_SEL_EN = 7;
   localparam int CTL_POL = 6;
   localparam int CTL_MASTER = 5;
   localparam int SEC_HI = 4;
   localparam int SEC_LO = 2;
   localparam int PRI_HI = 1;
   localparam int PRI_LO = 0;
   // data path
   localparam int WORD_W = 16;
   localparam int CNT_W = 4;
   localparam logic [CNT_W-1:0] MSB8 = 4'h7;
   localparam logic [CNT_W-1:0] MSB16 = 4'hf;
   localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
   localparam logic [WORD_W-1:0] BYTE_MASK = 16'h00ff;
   localparam logic [WORD_W-1:0] WORD_MASK = 16'hffff;
   // two-entry transmit buffer
   localparam int DEPTH = 2;
   localparam logic [1:0] FILL_FULL = 2'h2;
   localparam logic [1:0] FILL_ONE = 2'h1;
   // divider
   localparam int DIV_W = 10;
   localparam logic [DIV_W-1:0] DIV_ONE = 10'h001;
   localparam logic [DIV_W-1:0] PRI_R1 = 10'h001;
   localparam logic [DIV_W-1:0] PRI_R4 = 10'h004;
   localparam logic [DIV_W-1:0] PRI_R16 = 10'h010;
   localparam logic [DIV_W-1:0] PRI_R64 = 10'h040;
   localparam logic [DIV_W-1:0] SEC_R1 = 10'h001;
   localparam logic [DIV_W-1:0] SEC_R2 = 10'h002;
   localparam logic [DIV_W-1:0] SEC_R4 = 10'h004;
   localparam logic [DIV_W-1:0] SEC_R6 = 10'h006;
   localparam logic [DIV_W-1:0] SEC_R8 = 10'h008;
   // peer clock half period in sys_clk cycles
   localparam logic [DIV_W-1:0] PEER_HALF = 10'h004;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SYNC = 2'b01,
      ST_SHIFT = 2'b10
   } fspi_state_type;

   function automatic logic [DIV_W-1:0] prim_ratio(input logic [1:0] sel);
      case (sel)
         2'h3: prim_ratio = PRI_R1;
         2'h2: prim_ratio = PRI_R4;
         2'h1: prim_ratio = PRI_R16;
         default: prim_ratio = PRI_R64;
      endcase
   endfunction : prim_ratio

   function automatic logic [DIV_W-1:0] sec_ratio(input logic [2:0] sel);
      case (sel)
         3'h7: sec_ratio = SEC_R1;
         3'h6: sec_ratio = SEC_R2;
         3'h5: sec_ratio = SEC_R4;
         3'h4: sec_ratio = SEC_R6;
         default: sec_ratio = SEC_R8;
      endcase
   endfunction : sec_ratio
endpackage : fspi_pkg

//--- hdl/fspi_if.sv
/*
 four-wire framed serial link between device end and peer end.
 clock and sync are shared two-way wires resolved from both enables;
 an undriven wire reads low.
*/
`timescale 1ns/10ps
`default_nettype none
interface fspi_if;
   logic dev_sck_o;
   logic dev_sck_oe;
   logic dev_fs_o;
   logic dev_fs_oe;
   logic dev_sdo;
   logic peer_sck_o;
   logic peer_sck_oe;
   logic peer_fs_o;
   logic peer_fs_oe;
   logic peer_sdo;
   logic sck_w;
   logic fs_w;

   // wire resolution
   assign sck_w = dev_sck_oe ? dev_sck_o : (peer_sck_oe & peer_sck_o);
   assign fs_w = dev_fs_oe ? dev_fs_o : (peer_fs_oe & peer_fs_o);

   modport dev (
      output dev_sck_o, dev_sck_oe, dev_fs_o, dev_fs_oe, dev_sdo,
      input sck_w, fs_w, peer_sdo
   );
   modport peer (
      output peer_sck_o, peer_sck_oe, peer_fs_o, peer_fs_oe, peer_sdo,
      input sck_w, fs_w, dev_sdo
   );
endinterface : fspi_if
`default_nettype wire

//--- hdl/fspi_dev.sv
/*
 device end: framed serial port engine with clock divider and a
 two-entry transmit buffer.
 assumes link inputs synchronous to sys_clk and a peer that keeps
 its own side of the framing.
*/
`timescale 1ns/10ps
`default_nettype none
module fspi_dev (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // control
   input wire logic [fspi_pkg::CTL_W-1:0] control_word,
   input wire logic done_clear,
   // words to send
   input wire logic [fspi_pkg::WORD_W-1:0] tx_data,
   input wire logic tx_valid,
   output logic tx_ready,
   // words received
   output logic [fspi_pkg::WORD_W-1:0] rx_data,
   output logic rx_valid,
   output logic transfer_done_flag,
   // serial link
   fspi_if.dev link
);
   logic frame_en_w;
   logic frame_dir_w;
   logic master_w;
   logic pol_w;
   logic wide_w;
   logic frame_mst_w;
   logic frame_slv_w;
   logic [fspi_pkg::DIV_W-1:0] prod_w;
   logic [fspi_pkg::DIV_W-1:0] half_w;
   logic [fspi_pkg::DIV_W-1:0] div_cnt_r;
   logic [fspi_pkg::DIV_W-1:0] div_cnt_nxt;
   logic run_w;
   logic tick_w;
   logic sck_r;
   logic sck_oe_r;
   logic sck_in_r;
   logic level_w;
   logic edge_w;
   logic tx_edge_w;
   logic smp_edge_w;
   logic [fspi_pkg::WORD_W-1:0] fifo_mem_r [0:fspi_pkg::DEPTH-1];
   logic rd_ptr_r;
   logic wr_ptr_r;
   logic [1:0] fill_r;
   logic [1:0] fill_nxt;
   logic push_w;
   logic pop_w;
   logic have_w;
   logic [fspi_pkg::WORD_W-1:0] head_w;
   logic [fspi_pkg::WORD_W-1:0] hold_r;
   logic [fspi_pkg::WORD_W-1:0] load_word_w;
   fspi_pkg::fspi_state_type state_r;
   fspi_pkg::fspi_state_type state_nxt;
   logic idle_w;
   logic sync_w;
   logic shift_w;
   logic launch_w;
   logic arm_w;
   logic start_w;
   logic last_w;
   logic [fspi_pkg::CNT_W-1:0] msb_w;
   logic [fspi_pkg::CNT_W-1:0] bit_cnt_r;
   logic [fspi_pkg::WORD_W-1:0] sr_r;
   logic [fspi_pkg::WORD_W-1:0] shifted_w;
   logic fs_r;
   logic fs_oe_r;
   logic sdo_r;
   logic tx_ready_r;
   logic [fspi_pkg::WORD_W-1:0] rx_data_r;
   logic rx_valid_r;
   logic done_r;

   // control decode
   assign frame_en_w = control_word[fspi_pkg::CTL_FRAME_EN];
   assign frame_dir_w = control_word[fspi_pkg::CTL_FRAME_DIR];
   assign master_w = control_word[fspi_pkg::CTL_MASTER];
   assign pol_w = control_word[fspi_pkg::CTL_POL];
   assign wide_w = control_word[fspi_pkg::CTL_WIDTH];
   assign frame_mst_w = frame_en_w & ~frame_dir_w;
   assign frame_slv_w = frame_en_w & frame_dir_w;

   // clock divider
   assign prod_w = fspi_pkg::prim_ratio(
      control_word[fspi_pkg::PRI_HI:fspi_pkg::PRI_LO])
      * fspi_pkg::sec_ratio(
      control_word[fspi_pkg::SEC_HI:fspi_pkg::SEC_LO]);
   assign half_w = (prod_w > fspi_pkg::DIV_ONE) ? (prod_w >> 1)
      : fspi_pkg::DIV_ONE;
   assign run_w = master_w & (frame_en_w | !idle_w);
   assign tick_w = run_w & (div_cnt_r == half_w - fspi_pkg::DIV_ONE);
   assign div_cnt_nxt = (run_w & ~tick_w)
      ? div_cnt_r + fspi_pkg::DIV_ONE : '0;

   // edge classification
   assign level_w = master_w ? ~sck_r : link.sck_w;
   assign edge_w = master_w ? tick_w : (link.sck_w != sck_in_r);
   assign tx_edge_w = edge_w & (level_w ^ pol_w);
   assign smp_edge_w = edge_w & ~(level_w ^ pol_w);

   // transmit buffer
   assign push_w = tx_valid & tx_ready_r;
   assign have_w = fill_r != '0;
   assign head_w = fifo_mem_r[rd_ptr_r];
   assign pop_w = start_w & have_w;
   assign fill_nxt = fill_r + {1'b0, push_w} - {1'b0, pop_w};
   assign load_word_w = have_w ? head_w : hold_r;

   // sequencing
   assign idle_w = state_r == fspi_pkg::ST_IDLE;
   assign sync_w = state_r == fspi_pkg::ST_SYNC;
   assign shift_w = state_r == fspi_pkg::ST_SHIFT;
   assign launch_w = idle_w & frame_mst_w & have_w & tx_edge_w;
   assign arm_w = idle_w & frame_slv_w & smp_edge_w & link.fs_w;
   assign start_w = (sync_w & tx_edge_w)
      | (idle_w & ~frame_en_w & (master_w ? have_w : tx_edge_w));
   assign msb_w = wide_w ? fspi_pkg::MSB16 : fspi_pkg::MSB8;
   assign last_w = shift_w & smp_edge_w & (bit_cnt_r == msb_w);
   assign shifted_w = {sr_r[fspi_pkg::WORD_W-2:0], link.peer_sdo};

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         fspi_pkg::ST_IDLE: begin
            if (launch_w | arm_w) begin
               state_nxt = fspi_pkg::ST_SYNC;
            end else if (start_w) begin
               state_nxt = fspi_pkg::ST_SHIFT;
            end
         end
         fspi_pkg::ST_SYNC: begin
            if (start_w) begin
               state_nxt = fspi_pkg::ST_SHIFT;
            end
         end
         fspi_pkg::ST_SHIFT: begin
            if (last_w) begin
               state_nxt = fspi_pkg::ST_IDLE;
            end
         end
         default: state_nxt = fspi_pkg::ST_IDLE;
      endcase
   end

   // serial clock
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         div_cnt_r <= '0;
         sck_r <= '0;
         sck_oe_r <= '0;
         sck_in_r <= '0;
      end else begin
         div_cnt_r <= div_cnt_nxt;
         sck_oe_r <= master_w;
         sck_in_r <= link.sck_w;
         if (!run_w) begin
            sck_r <= pol_w;
         end else if (tick_w) begin
            sck_r <= ~sck_r;
         end
      end
   end

   // buffer storage
   always_ff @(posedge sys_clk) begin
      if (push_w) begin
         fifo_mem_r[wr_ptr_r] <= tx_data;
      end
   end

   // buffer pointers and stale word
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         rd_ptr_r <= '0;
         wr_ptr_r <= '0;
         fill_r <= '0;
         tx_ready_r <= 1'b1;
         hold_r <= '0;
      end else begin
         rd_ptr_r <= rd_ptr_r ^ pop_w;
         wr_ptr_r <= wr_ptr_r ^ push_w;
         fill_r <= fill_nxt;
         tx_ready_r <= fill_nxt != fspi_pkg::FILL_FULL;
         if (pop_w) begin
            hold_r <= head_w;
         end
      end
   end

   // sync pin and flags
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         state_r <= fspi_pkg::ST_IDLE;
         fs_r <= '0;
         fs_oe_r <= '0;
         rx_valid_r <= '0;
         done_r <= '0;
      end else begin
         state_r <= state_nxt;
         fs_oe_r <= frame_mst_w;
         rx_valid_r <= last_w;
         done_r <= last_w | (done_r & ~done_clear);
         if (launch_w) begin
            fs_r <= 1'b1;
         end else if (sync_w & tx_edge_w) begin
            fs_r <= '0;
         end
      end
   end

   // shift register
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         sr_r <= '0;
         sdo_r <= '0;
         bit_cnt_r <= '0;
         rx_data_r <= '0;
      end else begin
         if (start_w) begin
            sr_r <= load_word_w;
            sdo_r <= load_word_w[msb_w];
            bit_cnt_r <= '0;
         end else if (shift_w) begin
            if (smp_edge_w) begin
               sr_r <= shifted_w;
               bit_cnt_r <= bit_cnt_r + fspi_pkg::CNT_ONE;
            end
            if (tx_edge_w) begin
               sdo_r <= sr_r[msb_w];
            end
         end
         if (last_w) begin
            rx_data_r <= shifted_w & (wide_w ? fspi_pkg::WORD_MASK
               : fspi_pkg::BYTE_MASK);
         end
      end
   end

   // outputs
   assign tx_ready = tx_ready_r;
   assign rx_data = rx_data_r;
   assign rx_valid = rx_valid_r;
   assign transfer_done_flag = done_r;
   assign link.dev_sck_o = sck_r;
   assign link.dev_sck_oe = sck_oe_r;
   assign link.dev_fs_o = fs_r;
   assign link.dev_fs_oe = fs_oe_r;
   assign link.dev_sdo = sdo_r;
endmodule : fspi_dev
`default_nettype wire

//--- hdl/fspi_peer.sv
/*
 peer end: remote processor on the framed link, always framed.
 optionally makes a free-running clock and the sync pulse.
 assumes link inputs synchronous to sys_clk.
*/
`timescale 1ns/10ps
`default_nettype none
module fspi_peer (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // roles
   input wire logic makes_clock,
   input wire logic makes_sync,
   input wire logic polarity,
   input wire logic wide,
   // word to send
   input wire logic send,
   input wire logic [fspi_pkg::WORD_W-1:0] send_data,
   // word received
   output logic [fspi_pkg::WORD_W-1:0] rx_data,
   output logic rx_valid,
   // serial link
   fspi_if.peer link
);
   logic [fspi_pkg::DIV_W-1:0] div_cnt_r;
   logic tick_w;
   logic sck_r;
   logic sck_oe_r;
   logic sck_in_r;
   logic level_w;
   logic edge_w;
   logic tx_edge_w;
   logic smp_edge_w;
   logic pending_r;
   logic [fspi_pkg::WORD_W-1:0] word_r;
   fspi_pkg::fspi_state_type state_r;
   logic launch_w;
   logic arm_w;
   logic start_w;
   logic last_w;
   logic [fspi_pkg::CNT_W-1:0] msb_w;
   logic [fspi_pkg::CNT_W-1:0] bit_cnt_r;
   logic [fspi_pkg::WORD_W-1:0] sr_r;
   logic [fspi_pkg::WORD_W-1:0] shifted_w;
   logic fs_r;
   logic fs_oe_r;
   logic sdo_r;
   logic [fspi_pkg::WORD_W-1:0] rx_data_r;
   logic rx_valid_r;

   assign tick_w = makes_clock
      & (div_cnt_r == fspi_pkg::PEER_HALF - fspi_pkg::DIV_ONE);
   assign level_w = makes_clock ? ~sck_r : link.sck_w;
   assign edge_w = makes_clock ? tick_w : (link.sck_w != sck_in_r);
   assign tx_edge_w = edge_w & (level_w ^ polarity);
   assign smp_edge_w = edge_w & ~(level_w ^ polarity);
   assign launch_w = (state_r == fspi_pkg::ST_IDLE) & makes_sync
      & pending_r & tx_edge_w;
   assign arm_w = (state_r == fspi_pkg::ST_IDLE) & ~makes_sync
      & smp_edge_w & link.fs_w;
   assign start_w = (state_r == fspi_pkg::ST_SYNC) & tx_edge_w;
   assign msb_w = wide ? fspi_pkg::MSB16 : fspi_pkg::MSB8;
   assign last_w = (state_r == fspi_pkg::ST_SHIFT) & smp_edge_w
      & (bit_cnt_r == msb_w);
   assign shifted_w = {sr_r[fspi_pkg::WORD_W-2:0], link.dev_sdo};

   // free-running clock
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         div_cnt_r <= '0;
         sck_r <= '0;
         sck_oe_r <= '0;
         sck_in_r <= '0;
      end else begin
         div_cnt_r <= (makes_clock & ~tick_w)
            ? div_cnt_r + fspi_pkg::DIV_ONE : '0;
         sck_oe_r <= makes_clock;
         sck_in_r <= link.sck_w;
         if (!makes_clock) begin
            sck_r <= polarity;
         end else if (tick_w) begin
            sck_r <= ~sck_r;
         end
      end
   end

   // framing and shifting
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         pending_r <= '0;
         word_r <= '0;
         state_r <= fspi_pkg::ST_IDLE;
         fs_r <= '0;
         fs_oe_r <= '0;
         sdo_r <= '0;
         sr_r <= '0;
         bit_cnt_r <= '0;
         rx_data_r <= '0;
         rx_valid_r <= '0;
      end else begin
         pending_r <= send | (pending_r & ~launch_w);
         if (send) begin
            word_r <= send_data;
         end
         fs_oe_r <= makes_sync;
         rx_valid_r <= last_w;
         if (launch_w) begin
            fs_r <= 1'b1;
         end else if (start_w) begin
            fs_r <= '0;
         end
         if (launch_w | arm_w) begin
            state_r <= fspi_pkg::ST_SYNC;
         end else if (start_w) begin
            state_r <= fspi_pkg::ST_SHIFT;
            sr_r <= word_r;
            sdo_r <= word_r[msb_w];
            bit_cnt_r <= '0;
         end else if (state_r == fspi_pkg::ST_SHIFT) begin
            if (smp_edge_w) begin
               sr_r <= shifted_w;
               bit_cnt_r <= bit_cnt_r + fspi_pkg::CNT_ONE;
            end
            if (tx_edge_w) begin
               sdo_r <= sr_r[msb_w];
            end
            if (last_w) begin
               state_r <= fspi_pkg::ST_IDLE;
               rx_data_r <= shifted_w & (wide ? fspi_pkg::WORD_MASK
                  : fspi_pkg::BYTE_MASK);
            end
         end
      end
   end

   assign rx_data = rx_data_r;
   assign rx_valid = rx_valid_r;
   assign link.peer_sck_o = sck_r;
   assign link.peer_sck_oe = sck_oe_r;
   assign link.peer_fs_o = fs_r;
   assign link.peer_fs_oe = fs_oe_r;
   assign link.peer_sdo = sdo_r;
endmodule : fspi_peer
`default_nettype wire

//--- dv/fspi_asserts.sv
/*
 concurrent checks on the framed serial link wires.
 assumes sys_clk domain signals and a synchronous active-high reset.
*/
`timescale 1ns/10ps
`default_nettype none
module fspi_asserts (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // device end
   input wire logic dev_sck_o,
   input wire logic dev_sck_oe,
   input wire logic dev_fs_o,
   input wire logic dev_fs_oe,
   input wire logic dev_sdo,
   // peer end
   input wire logic peer_sck_o,
   input wire logic peer_sck_oe,
   input wire logic peer_fs_o,
   input wire logic peer_fs_oe,
   input wire logic peer_sdo,
   // resolved wires
   input wire logic sck_w,
   input wire logic fs_w,
   // configuration
   input wire logic polarity
);
   logic sck_q_r;
   logic [2:0] hi_cnt_r;
   logic [2:0] hi_cnt_nxt;
   logic tx_lvl_r;
   logic lvl_ok_r;
   logic sck_tog;

   // clock toggles counted while sync is high
   assign sck_tog = sck_w ^ sck_q_r;
   assign hi_cnt_nxt = !fs_w ? 3'h0 :
      (sck_tog && hi_cnt_r != 3'h7) ? hi_cnt_r + 3'h1 : hi_cnt_r;

   always_ff @(posedge sys_clk) begin
      sck_q_r <= sck_w;
      hi_cnt_r <= reset ? 3'h0 : hi_cnt_nxt;
   end

   // clock level at which the device launched its sync
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         lvl_ok_r <= 1'b0;
         tx_lvl_r <= 1'b0;
      end else if (dev_sck_oe && $rose(dev_fs_o)) begin
         lvl_ok_r <= 1'b1;
         tx_lvl_r <= dev_sck_o;
      end
   end

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (reset);

   sequence s_sync_end;
      dev_sck_oe && $fell(dev_fs_o);
   endsequence
   sequence s_quiet;
      !dev_fs_o [*8];
   endsequence

   a_sck_oe_excl: assert property (!(dev_sck_oe && peer_sck_oe))
      else $error("both ends drive the clock");
   a_fs_oe_excl: assert property (!(dev_fs_oe && peer_fs_oe))
      else $error("both ends drive the sync");
   a_fs_one_period: assert property ($fell(fs_w) |-> hi_cnt_r == 3'h2)
      else $error("sync pulse not one clock period");
   a_fs_tx_edge: assert property (dev_sck_oe && $changed(dev_fs_o)
      |-> $changed(dev_sck_o)) else $error("sync moved off a clock edge");
   a_sdo_tx_edge: assert property (dev_sck_oe && $changed(dev_sdo)
      |-> $changed(dev_sck_o)) else $error("data moved off a clock edge");
   a_sdo_same_edge: assert property (lvl_ok_r && dev_sck_oe
      && $changed(dev_sdo) |-> dev_sck_o == tx_lvl_r)
      else $error("data and sync use different edges");
   a_sync_pol_level: assert property (dev_sck_oe && $rose(dev_fs_o)
      |-> dev_sck_o != polarity) else $error("sync launched on sample edge");
   a_peer_sdo_edge: assert property (peer_sck_oe && $changed(peer_sdo)
      |-> $changed(peer_sck_o)) else $error("peer data off its edge");
   a_fs_gap: assert property (s_sync_end |-> s_quiet)
      else $error("sync repeated during shifting");
endmodule : fspi_asserts
`default_nettype wire

//--- dv/framed_spi_sync_and_clock_test.sv
/*
 testbench: device end and peer end joined by the link interface.
 assumes the package and the two ends compiled before it.
*/
`timescale 1ns/10ps
`default_nettype none
module framed_spi_sync_and_clock_test;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic [15:0] control_word = 16'h0000;
   logic done_clear = 1'b0;
   logic [15:0] tx_data = 16'h0000;
   logic tx_valid = 1'b0;
   logic tx_ready;
   logic [15:0] dev_rx;
   logic dev_rx_valid;
   logic done_flag;
   logic makes_clock = 1'b0;
   logic makes_sync = 1'b0;
   logic polarity = 1'b0;
   logic wide = 1'b1;
   logic send = 1'b0;
   logic [15:0] send_data = 16'h0000;
   logic [15:0] peer_rx;
   logic peer_rx_valid;
   logic [15:0] msk = 16'hffff;
   logic [15:0] dev_q[$];
   logic [15:0] peer_q[$];
   logic [15:0] pw;
   logic [15:0] wa;
   logic [4:0] dv[7] = '{5'h1f, 5'h1b, 5'h16, 5'h13, 5'h01, 5'h1c, 5'h1f};
   int hf[7] = '{1, 1, 8, 3, 64, 32, 300};
   int error_cnt = 0;
   int checked = 0;
   int cyc = 0;

   fspi_if i_fspi_if();
   fspi_dev i_fspi_dev (.sys_clk(sys_clk), .reset(reset),
      .control_word(control_word), .done_clear(done_clear),
      .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
      .rx_data(dev_rx), .rx_valid(dev_rx_valid),
      .transfer_done_flag(done_flag), .link(i_fspi_if.dev));
   fspi_peer i_fspi_peer (.sys_clk(sys_clk), .reset(reset),
      .makes_clock(makes_clock), .makes_sync(makes_sync),
      .polarity(polarity), .wide(wide), .send(send),
      .send_data(send_data), .rx_data(peer_rx),
      .rx_valid(peer_rx_valid), .link(i_fspi_if.peer));
   fspi_asserts i_fspi_asserts (.sys_clk(sys_clk), .reset(reset),
      .dev_sck_o(i_fspi_if.dev_sck_o), .dev_sck_oe(i_fspi_if.dev_sck_oe),
      .dev_fs_o(i_fspi_if.dev_fs_o), .dev_fs_oe(i_fspi_if.dev_fs_oe),
      .dev_sdo(i_fspi_if.dev_sdo), .peer_sck_o(i_fspi_if.peer_sck_o),
      .peer_sck_oe(i_fspi_if.peer_sck_oe), .peer_fs_o(i_fspi_if.peer_fs_o),
      .peer_fs_oe(i_fspi_if.peer_fs_oe), .peer_sdo(i_fspi_if.peer_sdo),
      .sck_w(i_fspi_if.sck_w), .fs_w(i_fspi_if.fs_w),
      .polarity(polarity));

   always #2 sys_clk = ~sys_clk;

   task automatic summarize();
      $display("checked %0d error_cnt %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : summarize

   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         summarize();
      end
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : tick

   // control word: frame on, direction, width, ignored bits, polarity
   function automatic logic [15:0] mk_ctl(input logic dir, input logic wid,
      input logic pol, input logic mst, input logic [1:0] ign,
      input logic [4:0] div);
      mk_ctl = {1'b0, 1'b1, dir, 2'b00, wid, 1'b0, ign, pol, mst, div};
   endfunction : mk_ctl

   task automatic start(input logic [15:0] ctl, input logic mk_clk,
      input logic mk_sync, input logic pol, input logic wid);
      reset = 1'b1;
      control_word = ctl;
      makes_clock = mk_clk;
      makes_sync = mk_sync;
      polarity = pol;
      wide = wid;
      msk = wid ? 16'hffff : 16'h00ff;
      tick(3);
      reset = 1'b0;
   endtask : start

   task automatic push(input logic [15:0] w);
      logic ok;
      tx_data = w;
      tx_valid = 1'b1;
      ok = 1'b0;
      for (int i = 0; i < 3000 && !ok; i++) begin
         ok = (tx_ready === 1'b1);
         tick(1);
      end
      peer_q.push_back(w & msk);
   endtask : push

   task automatic peer_send(input logic [15:0] w);
      send_data = w;
      send = 1'b1;
      tick(1);
      send = 1'b0;
   endtask : peer_send

   task automatic drain();
      for (int i = 0; i < 3000 && dev_q.size() + peer_q.size() != 0; i++)
         tick(1);
      check(16'(dev_q.size() + peer_q.size()), 16'h0000);
   endtask : drain

   // clock half period while idle and framed; idle and unframed, the clock holds still
   task automatic measure(input logic [4:0] div, input int half);
      logic s;
      int n;
      start(mk_ctl(1'b0, 1'b1, 1'b0, 1'b1, 2'b00, div)
         & (half == 300 ? 16'hbfff : 16'hffff), 1'b0, 1'b0, 1'b0, 1'b1);
      tick(2);
      s = i_fspi_if.sck_w;
      for (int i = 0; i < 300 && i_fspi_if.sck_w === s; i++)
         tick(1);
      s = i_fspi_if.sck_w;
      n = 0;
      for (int i = 0; i < 300 && i_fspi_if.sck_w === s; i++) begin
         tick(1);
         n++;
      end
      check(n[15:0], half[15:0]);
   endtask : measure

   always @(negedge sys_clk) begin
      if (dev_rx_valid === 1'b1) begin
         check(16'(done_flag), 16'h0001);
         check(dev_rx, dev_q.size() != 0 ? dev_q.pop_front() : 'x);
      end
      if (peer_rx_valid === 1'b1)
         check(peer_rx, peer_q.size() != 0 ? peer_q.pop_front() : 'x);
   end

   initial begin
      void'($urandom(61892));
      for (int k = 0; k < 7; k++)
         measure(dv[k], hf[k]);
      // device makes clock and sync, buffer filled and refused
      start(mk_ctl(1'b0, 1'b1, 1'b0, 1'b1, 2'b00, 5'h1a), 1'b0, 1'b0, 1'b0,
         1'b1);
      pw = 16'($urandom);
      peer_send(pw);
      repeat (3) dev_q.push_back(pw);
      push(16'($urandom));
      push(16'($urandom));
      tx_valid = 1'b0;
      tick(1);
      check(16'(tx_ready), 16'h0000);
      push(16'($urandom));
      tx_valid = 1'b0;
      drain();
      check(16'(done_flag), 16'h0001);
      done_clear = 1'b1;
      tick(1);
      done_clear = 1'b0;
      check(16'(done_flag), 16'h0000);
      // peer makes clock and sync, then a stale resend
      start(mk_ctl(1'b1, 1'b1, 1'b0, 1'b0, 2'b00, 5'h00), 1'b1, 1'b1, 1'b0,
         1'b1);
      wa = 16'($urandom);
      push(wa);
      tx_valid = 1'b0;
      pw = 16'($urandom);
      dev_q.push_back(pw);
      peer_send(pw);
      drain();
      pw = 16'($urandom);
      dev_q.push_back(pw);
      peer_q.push_back(wa);
      peer_send(pw);
      drain();
      // clock from one end, sync from the other
      for (int k = 0; k < 2; k++) begin
         start(mk_ctl(k[0], 1'b1, 1'b0, k[0], 2'b00, 5'h1a), ~k[0], k[0],
            1'b0, 1'b1);
         wa = 16'($urandom);
         push(wa);
         tx_valid = 1'b0;
         pw = 16'($urandom);
         dev_q.push_back(pw);
         peer_send(pw);
         drain();
      end
      // byte words, polarity one, ignored bits set
      start(mk_ctl(1'b0, 1'b0, 1'b1, 1'b1, 2'b11, 5'h17), 1'b0, 1'b0, 1'b1,
         1'b0);
      pw = 16'($urandom);
      peer_send(pw);
      dev_q.push_back(pw & msk);
      push(16'($urandom));
      tx_valid = 1'b0;
      drain();
      summarize();
   end
endmodule : framed_spi_sync_and_clock_test
`default_nettype wire
